// *** hdl/osw_pkg.sv ***
package osw_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_REQUEST = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_CURRENT = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_FORCE = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 12'h018;

  // ----------------------------------------
  // Clock source codes
  // ----------------------------------------
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] SRC_HF1M = 3'h6;
  localparam logic [2:0] SRC_RSV5 = 3'h5;
  localparam logic [2:0] SRC_LF = 3'h4;
  localparam logic [2:0] SRC_SEC = 3'h3;
  localparam logic [2:0] SRC_RSV2 = 3'h2;
  localparam logic [2:0] SRC_EXT_PLL = 3'h1;
  localparam logic [2:0] SRC_HF_PLL = 3'h0;

  // ----------------------------------------
  // Divider codes and reset values
  // ----------------------------------------
  localparam logic [3:0] DIV_BY1 = 4'h0;
  localparam logic [3:0] DIV_BY512 = 4'h9;
  localparam logic [3:0] DIV_HF_RST = 4'h2;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRC_LSB = 4;
  localparam int CTL_HOLD = 7;
  localparam int CTL_PWR = 6;
  localparam int CTL_BYP = 5;
  localparam int CTL_DONE = 4;
  localparam int CTL_NSR = 3;
  localparam int OSC_EXT = 7;
  localparam int OSC_HF = 6;
  localparam int OSC_LF = 4;
  localparam int OSC_SEC = 3;
  localparam int OSC_ADC = 2;
  localparam int OSC_PLL = 0;
  localparam int IRQ_NSR = 0;
  localparam int IRQ_DONE = 1;

  // ----------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------
  localparam logic [REG_W-1:0] FORCE_MASK = 8'hdc;
  localparam logic [REG_W-1:0] IRQ_MASK = 8'h03;
  localparam logic [REG_W-1:0] REG_RST = 8'h00;

endpackage

// *** hdl/osw_sync_if.sv ***
`timescale 1ns/1ps
// Raw oscillator flags in, synchronised flags out
interface osw_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport syn (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// *** hdl/osw_sync.sv ***
`timescale 1ns/1ps
module osw_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  osw_sync_if.syn link
);

  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // Two-stage capture; stage1 feeds only stage2
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= link.raw;
      stage2_ff <= stage1_ff;
    end
  end

  assign link.synced = stage2_ff;

endmodule

// *** hdl/osw_top.sv ***
`timescale 1ns/1ps
module osw_top #(
  parameter logic [2:0] RST_SRC = osw_pkg::SRC_HF_PLL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [osw_pkg::ADDR_W-1:0] paddr,
  input wire logic [osw_pkg::DATA_W-1:0] pwdata,
  output logic [osw_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [osw_pkg::REG_W-1:0] osc_ready_raw,
  input wire logic [osw_pkg::REG_W-1:0] osc_demand,
  output logic [osw_pkg::REG_W-1:0] osc_enable,
  output logic [2:0] sys_src,
  output logic [3:0] sys_div,
  output logic pll_on,
  output logic pll_from_ext,
  output logic sec_high_power,
  output logic sec_crystal_mode,
  output logic sec_bypass_clk,
  output logic irq
);
  import osw_pkg::*;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  // Fast 1 MHz reset also starts at divide by 4
  localparam logic [3:0] RST_DIV =
    (RST_SRC == SRC_HF1M) ? DIV_HF_RST : DIV_BY1;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Multiplier paths use codes 000 and 001
  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == SRC_HF_PLL) || (s == SRC_EXT_PLL);
  endfunction

  // reserved codes remapped
  // Reserved request codes fall back to fast 1 MHz
  function automatic logic [2:0] legal_src(input logic [2:0] s);
    legal_src = ((s == SRC_RSV5) || (s == SRC_RSV2)) ? SRC_HF1M : s;
  endfunction

  // Ready flag of the oscillator behind a source code
  function automatic logic src_ready(input logic [2:0] s,
                                     input logic [REG_W-1:0] r);
    logic res;
    res = 1'b0;
    unique case (s)
      SRC_EXT: res = r[OSC_EXT];
      SRC_HF1M: res = r[OSC_HF];
      SRC_LF: res = r[OSC_LF];
      SRC_SEC: res = r[OSC_SEC];
      SRC_EXT_PLL: res = r[OSC_PLL];
      SRC_HF_PLL: res = r[OSC_PLL];
      default: res = 1'b0;
    endcase
    src_ready = res;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [2:0] req_src_ff;
  logic [3:0] req_div_ff;
  logic [2:0] cur_src_ff;
  logic [3:0] cur_div_ff;
  logic hold_ff;
  logic pwr_ff;
  logic byp_ff;
  logic [REG_W-1:0] force_ff;
  logic [REG_W-1:0] irq_st_ff;
  logic [REG_W-1:0] irq_msk_ff;
  logic nsr_prev_ff;
  logic [DATA_W-1:0] prdata_ff;
  logic [REG_W-1:0] stat_v;

  // ----------------------------------------
  // Ready synchroniser
  // ----------------------------------------
  logic [REG_W-1:0] rdy_s;
  osw_sync_if #(.W(REG_W)) rdy_if ();

  assign rdy_if.raw = osc_ready_raw;
  assign rdy_s = rdy_if.synced;

  osw_sync #(.W(REG_W)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .link(rdy_if)
  );

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic setup_ph;
  logic acc_ph;
  logic wr_acc;
  logic hit;
  logic [REG_W-1:0] wbyte;

  assign setup_ph = psel && !penable;
  assign acc_ph = psel && penable;
  assign wr_acc = acc_ph && pwrite;
  assign wbyte = pwdata[REG_W-1:0];
  assign pready = 1'b1;

  // Known offsets; anything else is an error answer
  always_comb begin
    unique case (paddr)
      OFS_REQUEST, OFS_CURRENT, OFS_CONTROL, OFS_STATUS,
      OFS_FORCE, OFS_IRQ_ST, OFS_IRQ_MSK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pslverr = acc_ph && !hit;

  // ----------------------------------------
  // Switch tracking
  // ----------------------------------------
  logic in_prog;
  logic new_rdy;
  logic new_src_ready;
  logic switch_go;
  logic switch_complete;

  assign in_prog = {req_src_ff, req_div_ff} != {cur_src_ff, cur_div_ff};
  assign switch_complete = !in_prog;

  // Target readiness comes from the enabled-and-ready view
  assign new_rdy = src_ready(req_src_ff, stat_v);

  assign new_src_ready = in_prog && new_rdy;

  assign switch_go = new_src_ready && !hold_ff;

  // ----------------------------------------
  // Request register
  // ----------------------------------------
  // same reset as current
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_src_ff <= RST_SRC;
      req_div_ff <= RST_DIV;
    end else if (wr_acc && paddr == OFS_REQUEST) begin
      req_src_ff <= legal_src(wbyte[SRC_LSB +: 3]);
      req_div_ff <= wbyte[3:0];
    end
  end

  // ----------------------------------------
  // Current clock register
  // ----------------------------------------
  // current follows request at switch
  // Nothing on the bus writes here, so it stays read-only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cur_src_ff <= RST_SRC;
      cur_div_ff <= RST_DIV;
    end else if (switch_go) begin
      cur_src_ff <= req_src_ff;
      cur_div_ff <= req_div_ff;
    end
  end

  assign sys_src = cur_src_ff;
  assign sys_div = cur_div_ff;

  // ----------------------------------------
  // Control bits
  // ----------------------------------------
  // hold stays until software clears it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_ff <= 1'b0;
      pwr_ff <= 1'b0;
      byp_ff <= 1'b0;
    end else if (wr_acc && paddr == OFS_CONTROL) begin
      hold_ff <= wbyte[CTL_HOLD];
      pwr_ff <= wbyte[CTL_PWR];
      byp_ff <= wbyte[CTL_BYP];
    end
  end

  // ----------------------------------------
  // Secondary oscillator mode
  // ----------------------------------------
  // bypass takes pin as clock input
  assign sec_bypass_clk = byp_ff;
  assign sec_crystal_mode = !byp_ff;
  assign sec_high_power = !byp_ff && pwr_ff;

  // ----------------------------------------
  // Force register and oscillator enables
  // ----------------------------------------
  // unimplemented force bits dropped
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      force_ff <= REG_RST;
    end else if (wr_acc && paddr == OFS_FORCE) begin
      force_ff <= wbyte & FORCE_MASK;
    end
  end

  // Oscillators a switch needs: current and requested paths
  logic [REG_W-1:0] need_v;
  logic [2:0] pll_src;

  // The multiplier input is the requested one while it is a
  // multiplier code, otherwise the running one
  assign pll_src = is_pll(req_src_ff) ? req_src_ff : cur_src_ff;
  assign pll_on = is_pll(req_src_ff) || is_pll(cur_src_ff);
  assign pll_from_ext = (pll_src == SRC_EXT_PLL);

  always_comb begin
    need_v = '0;
    need_v[OSC_EXT] = (req_src_ff == SRC_EXT) || (cur_src_ff == SRC_EXT)
                    || (pll_on && pll_from_ext);
    need_v[OSC_HF] = (req_src_ff == SRC_HF1M) || (cur_src_ff == SRC_HF1M)
                   || (pll_on && !pll_from_ext);
    need_v[OSC_LF] = (req_src_ff == SRC_LF) || (cur_src_ff == SRC_LF);
    need_v[OSC_SEC] = (req_src_ff == SRC_SEC) || (cur_src_ff == SRC_SEC);
  end

  assign osc_enable = (force_ff | need_v | osc_demand) & FORCE_MASK;

  // ----------------------------------------
  // Ready status
  // ----------------------------------------
  logic pll_in_rdy;

  assign pll_in_rdy = pll_from_ext ? rdy_s[OSC_EXT] : rdy_s[OSC_HF];

  // lock, enable and input all needed
  // A plain process, so every ready or enable change re-evaluates it
  always_comb begin
    stat_v = rdy_s & osc_enable;
    stat_v[OSC_PLL] = rdy_s[OSC_PLL] && pll_on && pll_in_rdy;
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  logic ev_nsr;
  logic rd_irq;
  logic [REG_W-1:0] ev_v;

  // flag rises with the ready bit
  assign ev_nsr = new_src_ready && !nsr_prev_ff;
  assign rd_irq = acc_ph && !pwrite && paddr == OFS_IRQ_ST;

  always_comb begin
    ev_v = '0;
    ev_v[IRQ_NSR] = ev_nsr;
    ev_v[IRQ_DONE] = switch_go;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nsr_prev_ff <= 1'b0;
    end else begin
      nsr_prev_ff <= new_src_ready;
    end
  end

  // Read clears only what it reported, so a flag set after the
  // setup capture is not lost; a same-cycle event still wins
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_st_ff <= REG_RST;
    end else begin
      irq_st_ff <= (rd_irq ? (irq_st_ff & ~prdata_ff[REG_W-1:0]) : irq_st_ff) | ev_v;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_msk_ff <= REG_RST;
    end else if (wr_acc && paddr == OFS_IRQ_MSK) begin
      irq_msk_ff <= wbyte & IRQ_MASK;
    end
  end

  assign irq = |(irq_st_ff & irq_msk_ff);

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [REG_W-1:0] rd_byte;

  always_comb begin
    rd_byte = REG_RST;
    unique case (paddr)
      OFS_REQUEST: rd_byte = {1'b0, req_src_ff, req_div_ff};
      OFS_CURRENT: rd_byte = {1'b0, cur_src_ff, cur_div_ff};
      OFS_CONTROL: begin
        rd_byte[CTL_HOLD] = hold_ff;
        rd_byte[CTL_PWR] = pwr_ff;
        rd_byte[CTL_BYP] = byp_ff;
        rd_byte[CTL_DONE] = switch_complete;
        rd_byte[CTL_NSR] = new_src_ready;
      end
      OFS_STATUS: rd_byte = stat_v;
      OFS_FORCE: rd_byte = force_ff;
      OFS_IRQ_ST: rd_byte = irq_st_ff;
      OFS_IRQ_MSK: rd_byte = irq_msk_ff;
      default: rd_byte = REG_RST;
    endcase
  end

  // Captured in setup, so data is steady through access
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata_ff <= '0;
    end else if (setup_ph && !pwrite) begin
      prdata_ff <= {{(DATA_W-REG_W){1'b0}}, rd_byte};
    end
  end

  assign prdata = prdata_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_held;
    new_src_ready && hold_ff ##1 hold_ff;
  endsequence

  switch_takes_a: assert property (
    switch_go |=> {cur_src_ff, cur_div_ff} ==
                  {$past(req_src_ff), $past(req_div_ff)})
    else $error("current clock missed the switch");

  hold_keeps_a: assert property (
    s_held |-> $stable(cur_src_ff) && $stable(cur_div_ff))
    else $error("held switch changed current clock");

  ready_flag_a: assert property (
    new_src_ready && !$past(new_src_ready) |=> irq_st_ff[IRQ_NSR])
    else $error("ready event left no flag");

  done_clears_a: assert property (
    switch_go && !(wr_acc && paddr == OFS_REQUEST) |=> !new_src_ready)
    else $error("ready bit stayed after switch");

  rsvd_remap_a: assert property (
    wr_acc && paddr == OFS_REQUEST &&
    (wbyte[6:4] == SRC_RSV5 || wbyte[6:4] == SRC_RSV2)
    |=> req_src_ff == SRC_HF1M)
    else $error("reserved request not remapped");

  sec_mode_a: assert property (
    byp_ff |-> !sec_high_power && !sec_crystal_mode)
    else $error("bypass left crystal drive on");

  pll_ready_a: assert property (
    stat_v[OSC_PLL] |-> pll_on && pll_in_rdy && rdy_s[OSC_PLL])
    else $error("multiplier ready without lock");

  force_on_a: assert property (
    wr_acc && paddr == OFS_FORCE && wbyte[OSC_LF]
    |=> osc_enable[OSC_LF])
    else $error("forced oscillator not enabled");

  done_bit_a: assert property (
    switch_go && !(wr_acc && paddr == OFS_REQUEST) |=> switch_complete)
    else $error("complete bit not raised");

  irq_clear_a: assert property (
    rd_irq && ev_v == '0 |=> (irq_st_ff & $past(prdata_ff[REG_W-1:0])) == REG_RST)
    else $error("status read did not clear");

endmodule

// *** tb/osw_osc_model.sv ***
`timescale 1ns/1ps
// Oscillator bank and multiplier stand-in; slow stretches every oscillator start-up but not the lock
module osw_osc_model #(
  parameter int START_DLY = 20,
  parameter int LOCK_DLY = 8
) (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] osc_enable,
  input wire logic pll_on,
  input wire logic pll_from_ext,
  output logic [7:0] osc_ready_raw
);
  int cnt[8];
  int lock_cnt;
  int lim;
  logic src_ok;

  // Start-up limit and multiplier input choice
  assign lim = slow ? START_DLY * 4 : START_DLY;
  assign src_ok = pll_from_ext ? osc_ready_raw[7] : osc_ready_raw[6];

  always @(posedge clk) begin
    for (int i = 1; i < 8; i++) begin
      if (!osc_enable[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < lim) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end

  // lock needs multiplier on and input ready
  always @(posedge clk) begin
    if (!(pll_on && src_ok)) begin
      lock_cnt <= 0;
    end else if (lock_cnt < LOCK_DLY) begin
      lock_cnt <= lock_cnt + 1;
    end
  end

  // Positions 5 and 1 carry no oscillator, so they stay low
  always_comb begin
    for (int i = 1; i < 8; i++) begin
      osc_ready_raw[i] = (i != 5) && (i != 1) && (cnt[i] >= lim);
    end
    osc_ready_raw[0] = lock_cnt >= LOCK_DLY;
  end
endmodule

// *** tb/oscillator_switch_status_tb_top.sv ***
`timescale 1ns/1ps
module oscillator_switch_status_tb_top;
  import osw_pkg::*;
  typedef struct {logic [11:0] a; logic w; logic [7:0] d; logic [7:0] x; logic e;} osw_row_t;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, pll_on, pll_from_ext, sec_high_power, sec_crystal_mode;
  logic sec_bypass_clk, irq;
  logic [7:0] osc_ready_raw, osc_demand = 0, osc_enable;
  logic [2:0] sys_src;
  logic [3:0] sys_div;
  int n_errors = 0, checks = 0, cyc = 0;
  osw_row_t rows[9];

  osw_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_ready_raw(osc_ready_raw), .osc_demand(osc_demand), .osc_enable(osc_enable),
    .sys_src(sys_src), .sys_div(sys_div), .pll_on(pll_on), .pll_from_ext(pll_from_ext),
    .sec_high_power(sec_high_power), .sec_crystal_mode(sec_crystal_mode),
    .sec_bypass_clk(sec_bypass_clk), .irq(irq));
  osw_osc_model osc (.clk(clk), .slow(slow), .osc_enable(osc_enable), .pll_on(pll_on),
    .pll_from_ext(pll_from_ext), .osc_ready_raw(osc_ready_raw));

  // ----------------------------------------
  // Clock, hang guard, shared tasks
  // ----------------------------------------
  always #5 clk = ~clk;

  // Whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One transfer; an idle edge after it keeps drivers single per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
  endtask

  task automatic rc(input logic [11:0] a, input logic [7:0] x, input logic [7:0] m);
    logic [31:0] r;
    logic e;
    apb(0, a, 8'h00, r, e);
    chk(r & {24'h000000, m}, {24'h000000, x & m});
  endtask

  // Wait with no limit of its own for the system clock to reach a source
  task automatic wait_src(input logic [2:0] s);
    while (sys_src !== s) @(posedge clk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{'{OFS_FORCE, 1, 8'hff, 8'hdc, 0}, '{OFS_FORCE, 1, 8'h00, 8'h00, 0},
      '{OFS_CURRENT, 1, 8'hff, 8'h00, 0}, '{OFS_REQUEST, 0, 8'h00, 8'h00, 0},
      '{OFS_IRQ_MSK, 1, 8'hff, 8'h03, 0}, '{OFS_CONTROL, 1, 8'h6f, 8'h70, 0},
      '{OFS_CONTROL, 1, 8'h00, 8'h10, 0}, '{OFS_IRQ_ST, 1, 8'hff, 8'h00, 0},
      '{12'h01c, 1, 8'hff, 8'h00, 1}};
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({sys_src, sys_div, irq}, 8'h00);
    foreach (rows[i]) begin
      logic [31:0] r;
      logic e;
      if (rows[i].w) apb(1, rows[i].a, rows[i].d, r, e);
      apb(0, rows[i].a, 8'h00, r, e);
      chk(r, {24'h000000, rows[i].x});
      chk(e, rows[i].e);
    end
    // Switch to external at divide-by-8 without hold
    wr(OFS_FORCE, 8'hc0);
    wr(OFS_REQUEST, 8'h73);
    rc(OFS_CONTROL, 8'h00, 8'h18);
    wait_src(SRC_EXT);
    @(posedge clk);
    chk({sys_div, irq}, 5'h07);
    rc(OFS_CURRENT, 8'h73, 8'hff);
    rc(OFS_CONTROL, 8'h10, 8'hff);
    rc(OFS_IRQ_ST, 8'h03, 8'hff);
    chk(irq, 1'b0);
    // Hold stalls the switch until released
    wr(OFS_CONTROL, 8'h80);
    wr(OFS_REQUEST, 8'h40);
    while (irq !== 1'b1) @(posedge clk);
    rc(OFS_CONTROL, 8'h88, 8'hff);
    chk(sys_src, SRC_EXT);
    wr(OFS_CONTROL, 8'h00);
    wait_src(SRC_LF);
    rc(OFS_CONTROL, 8'h10, 8'hff);
    rc(OFS_IRQ_ST, 8'h03, 8'hff);
    // Reserved code, with the interrupt masked off
    wr(OFS_IRQ_MSK, 8'h00);
    wr(OFS_REQUEST, 8'h50);
    rc(OFS_REQUEST, 8'h60, 8'hff);
    wait_src(SRC_HF1M);
    chk({sys_div, irq}, 5'h00);
    rc(OFS_IRQ_ST, 8'h03, 8'hff);
    // Multiplier fed from external, slow start-up
    slow <= 1;
    wr(OFS_REQUEST, 8'h10);
    wait_src(SRC_EXT_PLL);
    chk({pll_on, pll_from_ext}, 2'b11);
    rc(OFS_STATUS, 8'hc1, 8'hc1);
    wr(OFS_REQUEST, 8'h00);
    wait_src(SRC_HF_PLL);
    chk(pll_from_ext, 1'b0);
    // Demand from another block, then released
    slow <= 0;
    osc_demand <= 8'h04;
    repeat (30) @(posedge clk);
    rc(OFS_STATUS, 8'h04, 8'h04);
    osc_demand <= 8'h00;
    repeat (10) @(posedge clk);
    rc(OFS_STATUS, 8'h00, 8'h04);
    // Secondary oscillator modes
    wr(OFS_CONTROL, 8'h40);
    chk({sec_high_power, sec_crystal_mode, sec_bypass_clk}, 3'b110);
    wr(OFS_CONTROL, 8'h60);
    chk({sec_crystal_mode, sec_bypass_clk}, 2'b01);
    // Secondary as source, then the other reserved code
    wr(OFS_REQUEST, 8'h35);
    wait_src(SRC_SEC);
    rc(OFS_CURRENT, 8'h35, 8'hff);
    wr(OFS_REQUEST, 8'h21);
    rc(OFS_REQUEST, 8'h61, 8'hff);
    wait_src(SRC_HF1M);
    chk(sys_div, 4'h1);
    // Reset in mid-run
    rst_n <= 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk({sys_src, sys_div, irq}, 8'h00);
    rc(OFS_CONTROL, 8'h10, 8'hff);
    rc(OFS_FORCE, 8'h00, 8'hff);
    print_verdict();
  end
endmodule
